// [ceag_bank_join.sv]
// joins a bank byte and an in-bank offset into one 24-bit address
module ceag_bank_join
  import ceag_pkg::*;
(
  input wire logic [7:0] bank,
  input wire logic [15:0] offset,
  output logic [23:0] addr
);

  // bank above offset
  assign addr = {bank, offset}; // (RULE19)

endmodule : ceag_bank_join

// [ceag_chk.sv]
// port-level assertions for the effective-address generator
module ceag_chk
  import ceag_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire ceag_req_type req,
  input wire ceag_banks_type banks,
  input wire logic space_prefix,
  input wire logic [31:0] accumulator,
  input wire logic [31:0] long_general_register_0,
  input wire logic [31:0] long_general_register_1,
  input wire logic [31:0] long_general_register_2,
  input wire logic [31:0] long_general_register_3,
  input wire logic [23:0] vector_base,
  input wire ceag_res_type res,
  input wire logic res_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // short views of the request, result is one cycle behind
  wire logic go = req_valid;
  wire ceag_mode_type m = req.mode;
  wire logic [7:0] f = req.field[7:0];
  wire logic [31:0] lr = req.reg_sel[1] ? (req.reg_sel[0] ? long_general_register_3 : long_general_register_2)
    : (req.reg_sel[0] ? long_general_register_1 : long_general_register_0);
  valid_pulse_a: assert property (go |=> res_valid) else $error("no result after request");
  idle_hold_a: assert property (!go |=> !res_valid && $stable(res)) else $error("result moved while idle");
  pc_ind_a: assert property (go && m == CEAG_MODE_PC_IND |=> res.addr == {$past(banks.program_bank_register),
    $past(req.instr_addr[15:0] + CEAG_PC_IND_BIAS + req.field[15:0])}) else $error("pc indirect address");
  io_page_a: assert property (go && m inside {CEAG_MODE_IO, CEAG_MODE_IO_BIT}
    |=> res.addr == {16'h0000, $past(f)}) else $error("io address left page zero");
  long_disp_a: assert property (go && m == CEAG_MODE_LONG_DISP
    |=> res.addr == $past(lr[23:0] + {{16{f[7]}}, f})) else $error("long register displacement");
  bit_mask_a: assert property (go && m inside {CEAG_MODE_DIR_BIT, CEAG_MODE_IO_BIT, CEAG_MODE_ADDR_BIT}
    |=> res.bit_mask == 8'h01 << $past(req.bit_position_field)) else $error("bit mask");
  rel_wrap_a: assert property (go && m == CEAG_MODE_BR_REL |=> res.addr == {$past(banks.program_bank_register),
    $past(req.pc + {{8{f[7]}}, f})}) else $error("relative target");
  cycles_sum_a: assert property (go |=> res.cycles == $past(req.base_cycles + req.comp_cycles))
    else $error("cycle count");
  // main traffic kinds
  vect_c: cover property (go && m == CEAG_MODE_BR_VECT);
  list_c: cover property (go && m == CEAG_MODE_REG_LIST);
  back_c: cover property (go ##1 go);
endmodule : ceag_chk

bind ceag_top ceag_chk chk_u (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req(req), .banks(banks),
  .space_prefix(space_prefix), .accumulator(accumulator), .long_general_register_0(long_general_register_0),
  .long_general_register_1(long_general_register_1), .long_general_register_2(long_general_register_2),
  .long_general_register_3(long_general_register_3), .vector_base(vector_base), .res(res), .res_valid(res_valid));

// [ceag_pkg.sv]
// shared types and constants for the effective-address generator
package ceag_pkg;

  localparam int unsigned CEAG_ADDR_W = 24;
  localparam int unsigned CEAG_OFFS_W = 16;
  localparam int unsigned CEAG_BANK_W = 8;
  localparam logic [23:0] CEAG_IO_BASE = 24'h000000;
  localparam logic [15:0] CEAG_PC_IND_BIAS = 16'h0004;
  localparam logic [7:0] CEAG_ZERO_BANK = 8'h00;
  localparam logic [7:0] CEAG_ZERO_PAGE = 8'h00;
  localparam logic [23:0] CEAG_ADDR_RESET = 24'h000000;
  localparam logic [7:0] CEAG_CYC_RESET = 8'h00;

  // address-forming modes
  typedef enum logic [3:0] {
    CEAG_MODE_PC_IND = 4'h0,
    CEAG_MODE_ACC_BANK = 4'h1,
    CEAG_MODE_ACC_LONG = 4'h2,
    CEAG_MODE_IO = 4'h3,
    CEAG_MODE_LONG_DISP = 4'h4,
    CEAG_MODE_DIR_BIT = 4'h5,
    CEAG_MODE_IO_BIT = 4'h6,
    CEAG_MODE_ADDR_BIT = 4'h7,
    CEAG_MODE_BR_REL = 4'h8,
    CEAG_MODE_BR_ABS16 = 4'h9,
    CEAG_MODE_BR_ABS24 = 4'hA,
    CEAG_MODE_BR_ACC = 4'hB,
    CEAG_MODE_BR_CTX = 4'hC,
    CEAG_MODE_BR_VECT = 4'hD,
    CEAG_MODE_BR_MIND = 4'hE,
    CEAG_MODE_REG_LIST = 4'hF
  } ceag_mode_type;

  // bank and page registers of the core
  typedef struct packed {
    logic [7:0] program_bank_register;
    logic [7:0] data_bank_register;
    logic [7:0] direct_page_register;
  } ceag_banks_type;

  // one address request from the decoder
  typedef struct packed {
    ceag_mode_type mode;
    logic [23:0] instr_addr;
    logic [15:0] pc;
    logic [23:0] field;
    logic [2:0] bit_position_field;
    logic vect_long;
    logic [1:0] reg_sel;
    logic [7:0] base_cycles;
    logic [7:0] comp_cycles;
  } ceag_req_type;

  // one result
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0] bit_mask;
    logic [7:0] reg_select;
    logic [7:0] cycles;
    logic needs_fetch;
  } ceag_res_type;

endpackage : ceag_pkg

// [ceag_top.sv]
// effective-address and branch-target generator
// Contract
// (RULE1) pc-indirect: instruction address plus 4 plus offset
// (RULE2) keep plus 4 in loop/store/compare forms
// (RULE3) accumulator indirect: low half+data bank, or 24-bit
// (RULE4) io direct confined to page zero
// (RULE5) access-space prefix ignored for io direct
// (RULE6) long register plus signed byte, low 24
// (RULE7) compressed bit: operand, direct page, data bank
// (RULE8) bit position selects bit, high toward msb
// (RULE9) io bit address confined to page zero
// (RULE10) direct bit: 16-bit offset, data bank above
// (RULE11) register list bit one includes register
// (RULE12) relative branch wraps within program bank
// (RULE13) 16-bit branch uses program bank above
// (RULE14) 24-bit branch field is full address
// (RULE15) accumulator branch program bank; context jump data bank
// (RULE16) vector calls read 4 or 8-bit vector
// (RULE17) memory-indirect branch fetches word at address
// (RULE18) cycles equal base plus compensation
// (RULE19) output one 24-bit address, bank above offset
module ceag_top
  import ceag_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire ceag_req_type req,
  input wire ceag_banks_type banks,
  input wire logic space_prefix,
  input wire logic [31:0] accumulator,
  input wire logic [31:0] long_general_register_0,
  input wire logic [31:0] long_general_register_1,
  input wire logic [31:0] long_general_register_2,
  input wire logic [31:0] long_general_register_3,
  input wire logic [23:0] vector_base,
  output ceag_res_type res,
  output logic res_valid
);

  logic [15:0] accumulator_low_half;
  logic [15:0] word_offset_field;
  logic [7:0] byte_offset_field;
  logic [31:0] long_general_register;
  logic [23:0] long_sum;
  logic [15:0] pc_ind_offs;
  logic [15:0] rel_offs;
  logic [23:0] pc_ind_addr;
  logic [23:0] rel_addr;
  logic [23:0] abs16_addr;
  logic [23:0] acc_bank_addr;
  logic [23:0] br_acc_addr;
  logic [23:0] br_ctx_addr;
  logic [23:0] dir_addr;
  logic [23:0] addr16_bit_addr;
  logic [23:0] io_addr;
  logic [23:0] vect_addr;
  logic [7:0] vect_num;
  ceag_res_type res_d;
  ceag_res_type res_q;
  logic valid_q;

  // operand fields carved from the request
  assign accumulator_low_half = accumulator[15:0];
  assign word_offset_field = req.field[15:0];
  assign byte_offset_field = req.field[7:0];

  // long register pick
  always_comb begin
    unique case (req.reg_sel)
      2'h0: long_general_register = long_general_register_0;
      2'h1: long_general_register = long_general_register_1;
      2'h2: long_general_register = long_general_register_2;
      2'h3: long_general_register = long_general_register_3;
    endcase
  end

  // signed byte added to the long register, top byte dropped
  assign long_sum = 24'(long_general_register + {{24{byte_offset_field[7]}}, byte_offset_field}); // (RULE6)

  // always from the instruction's own address, not the next one, since
  // loop, store-immediate and compare forms are longer than four bytes
  assign pc_ind_offs = 16'(req.instr_addr[15:0] + CEAG_PC_IND_BIAS + word_offset_field); // (RULE1) (RULE2)

  // carry out of 16 bits is lost so the bank stays put
  assign rel_offs = 16'(req.pc + {{8{byte_offset_field[7]}}, byte_offset_field}); // (RULE12)

  // vector number width depends on the instruction
  assign vect_num = req.vect_long ? byte_offset_field : {4'h0, byte_offset_field[3:0]}; // (RULE16)
  // vectors are word entries counted down from the table base
  assign vect_addr = 24'(vector_base - {15'h0000, vect_num, 1'b0});

  // io space: prefix and bank registers play no part
  assign io_addr = {CEAG_ZERO_BANK, CEAG_ZERO_PAGE, byte_offset_field}; // (RULE4) (RULE5) (RULE9)

  ceag_bank_join u_pc_ind (
    .bank(banks.program_bank_register),
    .offset(pc_ind_offs),
    .addr(pc_ind_addr)
  );

  ceag_bank_join u_rel (
    .bank(banks.program_bank_register),
    .offset(rel_offs),
    .addr(rel_addr)
  );

  ceag_bank_join u_abs16 (
    .bank(banks.program_bank_register),
    .offset(word_offset_field),
    .addr(abs16_addr)
  );

  ceag_bank_join u_acc_bank (
    .bank(banks.data_bank_register),
    .offset(accumulator_low_half),
    .addr(acc_bank_addr)
  );

  ceag_bank_join u_br_acc (
    .bank(banks.program_bank_register),
    .offset(accumulator_low_half),
    .addr(br_acc_addr)
  );

  ceag_bank_join u_br_ctx (
    .bank(banks.data_bank_register),
    .offset(accumulator_low_half),
    .addr(br_ctx_addr)
  );

  ceag_bank_join u_dir (
    .bank(banks.data_bank_register),
    .offset({banks.direct_page_register, byte_offset_field}),
    .addr(dir_addr)
  );

  ceag_bank_join u_addr16_bit (
    .bank(banks.data_bank_register),
    .offset(word_offset_field),
    .addr(addr16_bit_addr)
  );

  // mode select of the address and side results
  always_comb begin
    res_d = '0;
    res_d.cycles = 8'(req.base_cycles + req.comp_cycles); // (RULE18)
    unique case (req.mode)
      CEAG_MODE_PC_IND: res_d.addr = pc_ind_addr; // (RULE1)
      CEAG_MODE_ACC_BANK: res_d.addr = acc_bank_addr; // (RULE3)
      CEAG_MODE_ACC_LONG: res_d.addr = accumulator[23:0]; // (RULE3)
      CEAG_MODE_IO: res_d.addr = io_addr; // (RULE4)
      CEAG_MODE_LONG_DISP: res_d.addr = long_sum; // (RULE6)
      CEAG_MODE_DIR_BIT: begin
        res_d.addr = dir_addr; // (RULE7)
        res_d.bit_mask = 8'h01 << req.bit_position_field; // (RULE8)
      end
      CEAG_MODE_IO_BIT: begin
        res_d.addr = io_addr; // (RULE9)
        res_d.bit_mask = 8'h01 << req.bit_position_field; // (RULE8)
      end
      CEAG_MODE_ADDR_BIT: begin
        res_d.addr = addr16_bit_addr; // (RULE10)
        res_d.bit_mask = 8'h01 << req.bit_position_field; // (RULE8)
      end
      CEAG_MODE_BR_REL: res_d.addr = rel_addr; // (RULE12)
      CEAG_MODE_BR_ABS16: res_d.addr = abs16_addr; // (RULE13)
      CEAG_MODE_BR_ABS24: res_d.addr = req.field; // (RULE14)
      CEAG_MODE_BR_ACC: res_d.addr = br_acc_addr; // (RULE15)
      CEAG_MODE_BR_CTX: res_d.addr = br_ctx_addr; // (RULE15)
      CEAG_MODE_BR_VECT: begin
        // the core reads the target word from this vector slot
        res_d.addr = vect_addr; // (RULE16)
        res_d.needs_fetch = 1'b1;
      end
      CEAG_MODE_BR_MIND: begin
        // address of the word that holds the destination
        res_d.addr = req.field; // (RULE17)
        res_d.needs_fetch = 1'b1;
      end
      CEAG_MODE_REG_LIST: res_d.reg_select = byte_offset_field; // (RULE11)
    endcase
  end

  // registered result, one cycle after the request
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      res_q <= '0;
    end else if (req_valid) begin
      res_q <= res_d;
    end
  end

  // valid flag follows the request by one cycle
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= req_valid;
    end
  end

  assign res = res_q;
  assign res_valid = valid_q;

endmodule : ceag_top

// [cpu_effective_address_gen_tb.sv]
// self-checking bench for the effective-address generator
module cpu_effective_address_gen_tb
  import ceag_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic space_prefix = 1'b0;
  ceag_req_type req = '0;
  ceag_banks_type banks = {8'h12, 8'h34, 8'h56};
  logic [31:0] acc = 32'hA1B2C3D4;
  ceag_res_type res;
  logic res_valid;
  logic [47:0] rows [16];
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  ceag_top dut_u (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid), .req(req), .banks(banks),
    .space_prefix(space_prefix), .accumulator(acc), .long_general_register_0(32'h33000090),
    .long_general_register_1(32'h01000000), .long_general_register_2(32'h02000000),
    .long_general_register_3(32'h03000000), .vector_base(24'hFFFFDC), .res(res), .res_valid(res_valid));
  initial forever #12.5 sys_clk = ~sys_clk;
  // hang guard, run needs well under 100 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 500) begin
      n_mismatch++;
      summarize();
    end
  end
  task automatic check(string what, logic [63:0] exp, logic [63:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h got %h", what, exp, got);
    end
  endtask : check
  // row index doubles as mode code, so rows stay short
  task automatic drive(int i);
    req.mode = ceag_mode_type'(i[3:0]);
    req.field = rows[i][47:24];
    req.bit_position_field = i[2:0];
    req.reg_sel = i[1:0];
    req.vect_long = 1'b1;
    req.pc = 16'hFFF0;
    req.base_cycles = 8'h10 + i[7:0];
    req.comp_cycles = 8'hF8;
    space_prefix = i[0];
    req_valid = 1'b1;
  endtask : drive
  function automatic ceag_res_type expect_res(int i);
    ceag_res_type e;
    e = '0;
    e.addr = rows[i][23:0];
    if (i >= 5 && i <= 7) e.bit_mask = 8'h01 << i[2:0];
    if (i == 15) e.reg_select = rows[i][31:24];
    e.needs_fetch = (i == 13 || i == 14);
    e.cycles = 8'h10 + i[7:0] + 8'hF8;
    return e;
  endfunction : expect_res
  task automatic special(int i, logic [15:0] pc, logic [23:0] fld, logic [23:0] a);
    @(negedge sys_clk);
    drive(i);
    req.pc = pc;
    req.field = fld;
    req.vect_long = 1'b0;
    @(negedge sys_clk);
    req_valid = 1'b0;
    check("special addr", a, res.addr);
  endtask : special
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  initial begin
    req.instr_addr = 24'h12FFFE;
    rows = '{48'h000010_120012, 48'h0_34C3D4, 48'h0_B2C3D4, 48'hFFFF7E_00007E,
      48'h000080_000010, 48'h00009A_34569A, 48'hABCD11_000011, 48'h00BEEF_34BEEF,
      48'h000020_120010, 48'h77ABCD_12ABCD, 48'h77ABCD_77ABCD, 48'h0_12C3D4,
      48'h0_34C3D4, 48'h000003_FFFFD6, 48'h123456_123456, 48'h0000A5_000000};
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
    check("idle valid", 64'h0, res_valid);
    // back to back stream, each result checked one cycle later
    for (int i = 0; i <= 16; i++) begin
      @(negedge sys_clk);
      if (i > 0) check("valid", 64'h1, res_valid);
      if (i > 0) check($sformatf("res mode %0d", i - 1), expect_res(i - 1), res);
      if (i < 16) drive(i);
      else req_valid = 1'b0;
    end
    req.field = 24'hFFFFFF;
    @(negedge sys_clk);
    check("idle valid", 64'h0, res_valid);
    check("held res", expect_res(15), res);
    special(13, 16'hFFF0, 24'h0000F3, 24'hFFFFD6);
    special(8, 16'h0005, 24'h0000F0, 24'h12FFF5);
    // reset in mid-run clears a pending result
    @(negedge sys_clk);
    drive(2);
    reset = 1'b1;
    @(negedge sys_clk);
    check("reset res", 64'h0, res);
    check("reset valid", 64'h0, res_valid);
    // a request in the very first cycle after release is taken
    reset = 1'b0;
    drive(9);
    @(negedge sys_clk);
    req_valid = 1'b0;
    check("post reset valid", 64'h1, res_valid);
    check("post reset res", expect_res(9), res);
    @(negedge sys_clk);
    check("post reset idle", 64'h0, res_valid);
    summarize();
  end
endmodule : cpu_effective_address_gen_tb
